// >>> hw/sram_port_host.sv
// host controller driving an asynchronous 32k x 8 static memory over its pins
`timescale 1ns/1ps
// How it works
// - write uses strobe low with both selects
// - read holds drive enable low for data
// - index held a full read cycle
// - select starts read, controls held steady
// - strobe rises first, ending the write
// - host drives data after strobe float delay
// - active-low select released after strobe, never ends early; active-high select stays high
module sram_port_host (
  // clock and control
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // user request
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [sram_port_pkg::ADDR_W-1:0] i_req_index,
  input wire logic [sram_port_pkg::DATA_W-1:0] i_req_wdata,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [sram_port_pkg::DATA_W-1:0] o_rsp_rdata,
  // memory pins
  output logic [sram_port_pkg::ADDR_W-1:0] o_mem_index,
  output logic o_select_active_low_n,
  output logic o_select_active_high,
  output logic o_write_strobe_n,
  output logic o_drive_enable_n,
  output logic [sram_port_pkg::DATA_W-1:0] o_mem_data,
  output logic o_mem_data_oe,
  input wire logic [sram_port_pkg::DATA_W-1:0] i_mem_data
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_READ = 6'b00_0010,
    ST_WSTROBE = 6'b00_0100,
    ST_WDATA = 6'b00_1000,
    ST_WHOLD = 6'b01_0000,
    ST_DONE = 6'b10_0000
  } state_t;

  typedef struct packed {
    state_t state;
    logic [3:0] cnt;
    logic [sram_port_pkg::ADDR_W-1:0] index;
    logic [sram_port_pkg::DATA_W-1:0] wdata;
    logic [sram_port_pkg::DATA_W-1:0] rdata;
    logic sel_n;
    logic strobe_n;
    logic drive_n;
    logic data_oe;
    logic rsp;
    logic [sram_port_pkg::DATA_W-1:0] sync1;
    logic [sram_port_pkg::DATA_W-1:0] sync2;
  } regs_t;

  localparam logic [3:0] READ_CNT = 4'(sram_port_pkg::READ_WAIT_CYC + 2); // two sync stages
  localparam logic [3:0] FLOAT_CNT = 4'(sram_port_pkg::FLOAT_WAIT_CYC);
  localparam logic [3:0] STROBE_CNT = 4'(sram_port_pkg::STROBE_CYC);
  localparam logic [3:0] HOLD_CNT = 4'(sram_port_pkg::HOLD_CYC);

  regs_t r;
  regs_t next_r;

  // request handshake is combinational
  assign o_req_ready = (r.state == ST_IDLE);

  // pins straight from flip-flops, except the active-high select, which is tied high
  assign o_mem_index = r.index;
  assign o_select_active_low_n = r.sel_n;
  assign o_select_active_high = 1'b1;
  assign o_write_strobe_n = r.strobe_n;
  assign o_drive_enable_n = r.drive_n;
  assign o_mem_data = r.wdata;
  assign o_mem_data_oe = r.data_oe;
  assign o_rsp_valid = r.rsp;
  assign o_rsp_rdata = r.rdata;

  // next state
  always_comb begin
    next_r = r;
    next_r.rsp = 1'b0;
    next_r.sync1 = i_mem_data;
    next_r.sync2 = r.sync1;
    if (r.cnt != sram_port_pkg::CNT_ZERO) begin
      next_r.cnt = r.cnt - 4'h1;
    end
    case (r.state)
      ST_IDLE: begin
        next_r.sel_n = 1'b1;
        next_r.strobe_n = 1'b1;
        next_r.drive_n = 1'b1;
        next_r.data_oe = 1'b0;
        if (i_req_valid) begin
          next_r.index = i_req_index;
          next_r.wdata = i_req_wdata;
          next_r.sel_n = 1'b0;
          if (i_req_write) begin
            // strobe and select fall together, so the pulse counts from here
            next_r.strobe_n = 1'b0;
            next_r.cnt = FLOAT_CNT;
            next_r.state = ST_WSTROBE;
          end else begin
            next_r.drive_n = 1'b0;
            // wait covers index, select and drive limits at once
            next_r.cnt = READ_CNT;
            next_r.state = ST_READ;
          end
        end
      end
      ST_READ: begin
        if (r.cnt == sram_port_pkg::CNT_ZERO) begin
          next_r.rdata = r.sync2;
          next_r.rsp = 1'b1;
          next_r.sel_n = 1'b1;
          next_r.drive_n = 1'b1;
          next_r.state = ST_DONE;
        end
      end
      ST_WSTROBE: begin
        // memory floats once the strobe is low; wait before driving
        if (r.cnt == sram_port_pkg::CNT_ZERO) begin
          next_r.data_oe = 1'b1;
          next_r.cnt = STROBE_CNT;
          next_r.state = ST_WDATA;
        end
      end
      ST_WDATA: begin
        if (r.cnt == sram_port_pkg::CNT_ZERO) begin
          next_r.strobe_n = 1'b1;
          next_r.cnt = HOLD_CNT;
          next_r.state = ST_WHOLD;
        end
      end
      ST_WHOLD: begin
        // data held past the rising strobe so the capture is clean
        if (r.cnt == sram_port_pkg::CNT_ZERO) begin
          next_r.data_oe = 1'b0;
          next_r.sel_n = 1'b1;
          next_r.rsp = 1'b1;
          next_r.state = ST_DONE;
        end
      end
      ST_DONE: begin
        // one idle cycle keeps index stable a full read cycle
        next_r.state = ST_IDLE;
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase
  end

  // state register, frozen while the enable is low
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      r <= '{state: ST_IDLE, cnt: 4'h0, index: 15'h0000, wdata: 8'h00, rdata: 8'h00,
             sel_n: 1'b1, strobe_n: 1'b1, drive_n: 1'b1, data_oe: 1'b0, rsp: 1'b0,
             sync1: 8'h00, sync2: 8'h00};
    end else if (i_clk_en) begin
      r <= next_r;
    end
  end

  // write control phases
  sequence s_wr_start;
    $fell(o_write_strobe_n);
  endsequence

  sequence s_float_wait;
    !o_mem_data_oe [*2];
  endsequence

  a_float_before_drive: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    s_wr_start |-> s_float_wait) else $error("data driven before float delay");

  a_no_contention: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !(o_mem_data_oe && !o_drive_enable_n)) else $error("both sides drive the bus");

  a_strobe_in_select: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !o_write_strobe_n |-> !o_select_active_low_n) else $error("strobe without select");

  a_idle_standby: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (r.state == ST_IDLE) |-> o_select_active_low_n) else $error("idle but selected");

  a_high_select: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_select_active_high) else $error("active high select dropped");

  a_data_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_clk_en && $rose(o_write_strobe_n)) |-> o_mem_data_oe && $stable(o_mem_data))
    else $error("data not held at strobe end");

  a_index_stable: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !o_select_active_low_n && $past(!o_select_active_low_n) |-> $stable(o_mem_index))
    else $error("index moved during access");

  a_read_wait: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_clk_en && $fell(o_drive_enable_n)) ##1 i_clk_en[*3] |-> !o_drive_enable_n)
    else $error("read ended before access time");

  a_deselect_after_strobe: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_select_active_low_n) |-> $past(o_write_strobe_n)) else $error("select ended write");

  // strobe must stay low long enough for the cell to take the byte
  a_strobe_width: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_clk_en && $fell(o_write_strobe_n)) ##1 i_clk_en[*3] |-> !o_write_strobe_n)
    else $error("write strobe too short");

  a_select_spans_data: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_mem_data_oe |-> !o_select_active_low_n) else $error("select released while driving");

  a_read_controls: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !o_drive_enable_n |-> !o_select_active_low_n && o_write_strobe_n)
    else $error("read controls not steady");
endmodule

// >>> hw/sram_port_pkg.sv
// constants for the external static memory controller
package sram_port_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 50;
  // access and cycle figures of the slowest speed grade
  localparam int INDEX_ACCESS_TIME_NS = 70;
  localparam int READ_CYCLE_TIME_NS = 70;
  localparam int SELECT_ACCESS_TIME_NS = 70;
  localparam int DRIVE_ACCESS_TIME_NS = 15;
  localparam int STROBE_PULSE_WIDTH_NS = 70;
  localparam int STROBE_TO_FLOAT_DELAY_NS = 30;
  localparam int DATA_HOLD_NS = 5;
  // cycle counts, least times rounded up
  localparam int READ_WAIT_CYC = (INDEX_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_WAIT_CYC = (STROBE_TO_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CNT_ZERO = 4'h0;
endpackage

// >>> dv/sram_model.sv
// behavioural static memory on the far side of the host controller
`timescale 1ns/1ps
module sram_model (
  // memory pins
  input wire logic [sram_port_pkg::ADDR_W-1:0] i_index,
  input wire logic i_sel_n,
  input wire logic i_sel,
  input wire logic i_strobe_n,
  input wire logic i_drive_n,
  input wire logic [sram_port_pkg::DATA_W-1:0] i_host_data,
  input wire logic i_host_oe,
  // data bus level and contention flag
  output logic [sram_port_pkg::DATA_W-1:0] o_data,
  output logic o_clash
);
  logic [7:0] mem [0:32767];
  logic act;
  logic drv;
  logic [15:0] key_d;
  assign act = !i_sel_n && i_sel;
  assign drv = act && i_strobe_n && !i_drive_n;
  // data only valid once the address and enables settled for the access time
  assign #(sram_port_pkg::INDEX_ACCESS_TIME_NS) key_d = {drv, i_index};
  assign o_clash = drv && i_host_oe;
  // floated bus shows the inverse, never a lucky match
  assign o_data = drv ? ((key_d == {1'b1, i_index}) ? mem[i_index] : ~mem[i_index])
    : (i_host_oe ? i_host_data : ~mem[i_index]);
  // stored at the edge ending the write
  always @(posedge i_strobe_n) if (act) mem[i_index] = i_host_oe ? i_host_data : 8'h5a;
  always @(negedge act) if (!i_strobe_n) mem[i_index] = i_host_oe ? i_host_data : 8'h5a;
endmodule

// >>> dv/sram_port_host_test.sv
// self-checking bench for the static memory host controller
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module sram_port_host_test;
  logic i_clk = 0, i_reset_n = 0, i_clk_en = 1, i_req_valid = 0, i_req_write = 0;
  logic [14:0] i_req_index = 15'h0000;
  logic [7:0] i_req_wdata = 8'h00, i_mem_data, o_rsp_rdata, o_mem_data;
  logic [14:0] o_mem_index;
  logic o_req_ready, o_rsp_valid, o_select_active_low_n, o_select_active_high;
  logic o_write_strobe_n, o_drive_enable_n, o_mem_data_oe, clash, clash_seen = 0;
  int err_total = 0, n_checks = 0, cyc = 0;
  sram_port_host dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_req_valid(i_req_valid),
    .i_req_write(i_req_write), .i_req_index(i_req_index), .i_req_wdata(i_req_wdata), .o_req_ready(o_req_ready),
    .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata), .o_mem_index(o_mem_index),
    .o_select_active_low_n(o_select_active_low_n), .o_select_active_high(o_select_active_high),
    .o_write_strobe_n(o_write_strobe_n), .o_drive_enable_n(o_drive_enable_n), .o_mem_data(o_mem_data),
    .o_mem_data_oe(o_mem_data_oe), .i_mem_data(i_mem_data));
  sram_model mem (.i_index(o_mem_index), .i_sel_n(o_select_active_low_n), .i_sel(o_select_active_high),
    .i_strobe_n(o_write_strobe_n), .i_drive_n(o_drive_enable_n), .i_host_data(o_mem_data),
    .i_host_oe(o_mem_data_oe), .o_data(i_mem_data), .o_clash(clash));
  initial forever #25 i_clk = ~i_clk;
  // watchdog and contention monitor
  always @(posedge i_clk) begin
    cyc++;
    if (clash === 1'b1) clash_seen = 1;
    if (cyc == 5000) begin err_total++; finish_test(); end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one request; clock enable dropped for hold cycles after the take
  task automatic do_req(input logic wr, input logic [14:0] idx, input logic [7:0] wd, input int hold);
    int n;
    n = 0;
    while (o_req_ready !== 1'b1 && n < 40) begin @(negedge i_clk); n++; end
    i_req_valid = 1; i_req_write = wr; i_req_index = idx; i_req_wdata = wd;
    @(negedge i_clk);
    i_req_valid = 0;
    i_clk_en = (hold == 0);
    repeat (hold) begin @(negedge i_clk); `CHK(o_rsp_valid, 1'b0) end
    `CHK(o_mem_index, idx)
    i_clk_en = 1;
    n = 0;
    while (o_rsp_valid !== 1'b1 && n < 40) begin
      `CHK(o_select_active_high, 1'b1)
      if (!wr) `CHK(o_mem_data_oe | ~o_write_strobe_n, 1'b0)
      @(negedge i_clk); n++;
    end
    `CHK(o_rsp_valid, 1'b1)
    if (!wr) `CHK(o_rsp_rdata, wd)
    @(negedge i_clk);
    // response is a single pulse and the memory is back in standby
    `CHK({o_rsp_valid, o_select_active_low_n}, 2'b01)
  endtask
  task automatic test_idle();
    `CHK({o_select_active_low_n, o_write_strobe_n, o_drive_enable_n, o_mem_data_oe}, 4'h7 << 1)
    `CHK(o_req_ready, 1'b1)
    $display("test idle done");
  endtask
  // corner indices back to back, then read back, some accesses frozen midway
  task automatic test_wr_rd();
    logic [14:0] ix [3] = '{15'h0000, 15'h7fff, 15'h2aa5};
    logic [7:0] dv [3] = '{8'ha5, 8'h3c, 8'hc3};
    for (int i = 0; i < 3; i++) do_req(1, ix[i], dv[i], i);
    for (int i = 0; i < 3; i++) do_req(0, ix[i], dv[i], 3 * i);
    test_idle();
    `CHK(clash_seen, 1'b0)
    $display("test write read done");
  endtask
  initial begin
    repeat (20) @(negedge i_clk);
    i_reset_n = 1;
    @(negedge i_clk);
    test_idle();
    test_wr_rd();
    finish_test();
  end
endmodule
